// ---- rtl/dci_pkg.sv ----
// Shared constants and types for the DSP instruction subset executor
package dci_pkg;

   localparam int WORD_W = 16;
   localparam int ACC_W  = 32;
   localparam int SHORT_IMMEDIATE_W = 8;
   localparam int RF_N   = 8;
   localparam int RF_IW  = 3;
   localparam int STK_N  = 4;
   localparam int CNT_W  = 6;

   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [WORD_W-1:0] PC_RST   = 16'h0000;
   localparam logic [ACC_W-1:0]  ACC_RST  = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  CNT_RST  = 6'h00;
   localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;
   localparam logic [ACC_W-1:0]  ACC_ONE  = 32'h0000_0001;
   localparam logic [RF_IW-1:0]  LC0_IDX  = 3'h6;
   localparam logic [RF_IW-1:0]  LC1_IDX  = 3'h7;

   typedef enum logic [4:0] {
      OP_NOP,
      OP_AND_PTR,
      OP_AND_IMM,
      OP_AND_SHORT_IMMEDIATE,
      OP_JUMP,
      OP_BREAK,
      OP_CALL,
      OP_LBC,
      OP_CLR_ACC,
      OP_CLR_REG,
      OP_CMP,
      OP_CMP_IMM,
      OP_CMP_SHORT_IMMEDIATE,
      OP_INV,
      OP_DOUBLE_WORD_ADD,
      OP_DOUBLE_WORD_SUBTRACT,
      OP_LOOP,
      OP_DEC_ACC,
      OP_DEC_REG,
      OP_DEC_MEM,
      OP_XOR_REG
   } dci_op_e;

   typedef enum logic [2:0] {
      COND_ALWAYS,
      COND_EQ,
      COND_NE,
      COND_LT,
      COND_GE,
      COND_GT,
      COND_LE,
      COND_CS
   } dci_cond_e;

   typedef enum logic [1:0] {
      SRC_REG,
      SRC_DMEM,
      SRC_PMEM
   } dci_src_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_DATA
   } dci_state_e;

   typedef struct packed {
      logic z;
      logic n;
      logic c;
      logic v;
   } dci_flags_s;

endpackage

// ---- rtl/dci_lbc_if.sv ----
// Interface between the core and its leading-bit counter
`timescale 1ns/1ns
interface dci_lbc_if;
   logic [dci_pkg::ACC_W-1:0] value;
   logic [dci_pkg::CNT_W-1:0] count;
   modport core (output value, input count);
   modport unit (input value, output count);
endinterface

// ---- rtl/dci_lead_count.sv ----
// Leading redundant sign bit counter for the accumulator
`timescale 1ns/1ns
module dci_lead_count (
   dci_lbc_if.unit lbc
);
   logic [dci_pkg::ACC_W-1:0] same;
   logic                      run;
   logic [dci_pkg::CNT_W-1:0] cnt;

   for (genvar g = 0; g < dci_pkg::ACC_W; g++) begin : g_same
      assign same[g] = lbc.value[g] == lbc.value[dci_pkg::ACC_W-1];
   end

   // Sign bit itself is not counted, so the result is 0 to 31
   always_comb begin
      run = 1'b1;
      cnt = dci_pkg::CNT_RST;
      for (int i = dci_pkg::ACC_W - 2; i >= 0; i--) begin
         run = run & same[i];
         cnt = cnt + {{(dci_pkg::CNT_W-1){1'b0}}, run};
      end
      lbc.count = cnt;
   end
endmodule

// ---- rtl/dci_core.sv ----
// Executor for a subset of the DSP core instruction set
`timescale 1ns/1ns
module dci_core (
   input  logic                          clk,
   input  logic                          rst_n,
   input  logic                          instr_valid,
   input  dci_pkg::dci_op_e              instr_op,
   input  dci_pkg::dci_cond_e            instr_cond,
   input  dci_pkg::dci_src_e             instr_src,
   input  logic                          instr_dw,
   input  logic                          instr_prod,
   input  logic [dci_pkg::RF_IW-1:0]     instr_idx,
   input  logic [dci_pkg::WORD_W-1:0]    instr_imm,
   input  logic [dci_pkg::WORD_W-1:0]    instr_target,
   input  logic                          debug_resume,
   input  logic                          ret_pop,
   input  logic                          reg_load_en,
   input  logic [dci_pkg::RF_IW-1:0]     reg_load_idx,
   input  logic [dci_pkg::WORD_W-1:0]    reg_load_data,
   input  logic [dci_pkg::WORD_W-1:0]    dmem_rdata,
   input  logic [dci_pkg::WORD_W-1:0]    pmem_rdata,
   output logic                          instr_ready,
   output logic                          retire,
   output logic                          halted,
   output logic [dci_pkg::WORD_W-1:0]    pc,
   output logic [dci_pkg::WORD_W-1:0]    return_top,
   output logic [dci_pkg::ACC_W-1:0]     acc,
   output logic [dci_pkg::WORD_W-1:0]    product_high_word,
   output logic [dci_pkg::WORD_W-1:0]    product_low_word,
   output dci_pkg::dci_flags_s           flags,
   output logic [dci_pkg::CNT_W-1:0]     lead_count,
   output logic [dci_pkg::WORD_W-1:0]    dmem_addr,
   output logic                          dmem_rd,
   output logic                          dmem_wr,
   output logic [dci_pkg::WORD_W-1:0]    dmem_wdata,
   output logic [dci_pkg::WORD_W-1:0]    pmem_addr,
   output logic                          pmem_rd
);
   localparam int W = dci_pkg::WORD_W;
   localparam int A = dci_pkg::ACC_W;
   localparam int S = dci_pkg::SHORT_IMMEDIATE_W;

   dci_pkg::dci_state_e       state_q;
   dci_pkg::dci_state_e       state_d;
   dci_pkg::dci_op_e          mop_q;
   dci_pkg::dci_src_e         msrc_q;
   dci_pkg::dci_flags_s       flags_q;
   dci_pkg::dci_flags_s       flg_d;
   logic [A-1:0]              acc_q;
   logic [A-1:0]              acc_d;
   logic [A-1:0]              prod;
   logic [A:0]                dsum;
   logic [A:0]                ddif;
   logic [W-1:0]              acc_hi;
   logic [W-1:0]              ph_q;
   logic [W-1:0]              pl_q;
   logic [W-1:0]              pc_q;
   logic [W-1:0]              pc_d;
   logic [W-1:0]              rf_q [dci_pkg::RF_N];
   logic [W-1:0]              rf_wd;
   logic [dci_pkg::RF_IW-1:0] rf_wi;
   logic [dci_pkg::RF_IW-1:0] lc_i;
   logic [W-1:0]              stk_q [dci_pkg::STK_N];
   logic [W-1:0]              push_src [dci_pkg::STK_N];
   logic [W-1:0]              pop_src [dci_pkg::STK_N];
   logic [W-1:0]              short_immediate_u;
   logic [W-1:0]              short_immediate_s;
   logic [W-1:0]              lres;
   logic [W-1:0]              mword;
   logic [dci_pkg::CNT_W-1:0] lcnt_q;
   logic [W-1:0]              daddr_q;
   logic [W-1:0]              wdata_q;
   logic [W-1:0]              paddr_q;
   logic                      drd_q;
   logic                      dwr_q;
   logic                      prd_q;
   logic                      halt_q;
   logic                      halt_d;
   logic                      ready_q;
   logic                      retire_q;
   logic                      accept;
   logic                      ok;
   logic                      lgc;
   logic                      acc_we;
   logic                      prod_we;
   logic                      flg_we;
   logic                      rf_we;
   logic                      pc_we;
   logic                      push;
   logic                      brk;
   logic                      lbc_we;
   logic                      go_mem;
   logic                      go_pmem;
   logic                      mem_wr;

   dci_lbc_if lbc ();

   dci_lead_count u_lbc (
      .lbc (lbc.unit)
   );

   function automatic logic cond_true(dci_pkg::dci_flags_s f, dci_pkg::dci_cond_e c);
      logic r;
      r = 1'b1;
      unique case (c)
         dci_pkg::COND_ALWAYS: r = 1'b1;
         dci_pkg::COND_EQ:     r = f.z;
         dci_pkg::COND_NE:     r = ~f.z;
         dci_pkg::COND_LT:     r = f.n ^ f.v;
         dci_pkg::COND_GE:     r = ~(f.n ^ f.v);
         dci_pkg::COND_GT:     r = ~f.z & ~(f.n ^ f.v);
         dci_pkg::COND_LE:     r = f.z | (f.n ^ f.v);
         dci_pkg::COND_CS:     r = f.c;
      endcase
      return r;
   endfunction

   // Accumulator minus operand; carry set means no borrow
   function automatic dci_pkg::dci_flags_s cmp16(logic [W-1:0] a, logic [W-1:0] b);
      logic [W:0]          d;
      dci_pkg::dci_flags_s f;
      d = {1'b0, a} - {1'b0, b};
      f.z = d[W-1:0] == dci_pkg::WORD_RST;
      f.n = d[W-1];
      f.c = ~d[W];
      f.v = (a[W-1] ^ b[W-1]) & (a[W-1] ^ d[W-1]);
      return f;
   endfunction

   assign lbc.value = acc_q;
   assign acc_hi    = acc_q[A-1:W];
   assign prod      = {ph_q, pl_q};
   assign dsum      = {1'b0, acc_q} + {1'b0, prod};
   assign ddif      = {1'b0, acc_q} - {1'b0, prod};
   assign short_immediate_u    = {{(W-S){1'b0}}, instr_imm[S-1:0]};
   assign short_immediate_s    = {{(W-S){instr_imm[S-1]}}, instr_imm[S-1:0]};
   assign mword     = (msrc_q == dci_pkg::SRC_PMEM) ? pmem_rdata : dmem_rdata;
   assign lc_i      = instr_idx[0] ? dci_pkg::LC1_IDX : dci_pkg::LC0_IDX;
   assign accept    = instr_valid & ready_q;
   assign ok        = cond_true(flags_q, instr_cond);

   always_comb begin
      acc_we  = 1'b0;
      acc_d   = acc_q;
      prod_we = 1'b0;
      flg_we  = 1'b0;
      flg_d   = flags_q;
      rf_we   = 1'b0;
      rf_wi   = instr_idx;
      rf_wd   = rf_q[instr_idx];
      pc_we   = 1'b0;
      pc_d    = pc_q + dci_pkg::WORD_ONE;
      push    = 1'b0;
      brk     = 1'b0;
      lbc_we  = 1'b0;
      go_mem  = 1'b0;
      go_pmem = 1'b0;
      mem_wr  = 1'b0;
      lgc     = 1'b0;
      lres    = acc_hi;
      if (state_q == dci_pkg::ST_IDLE && accept) begin
         pc_we = 1'b1;
         // A failed condition falls through with only the step to the next address
         if (ok) begin
            unique case (instr_op)
               dci_pkg::OP_NOP: begin
               end
               dci_pkg::OP_AND_PTR: begin
                  lres = acc_hi & rf_q[instr_idx];
                  lgc  = 1'b1;
               end
               dci_pkg::OP_AND_IMM: begin
                  lres = acc_hi & instr_imm;
                  lgc  = 1'b1;
               end
               dci_pkg::OP_AND_SHORT_IMMEDIATE: begin
                  lres = acc_hi & short_immediate_u;
                  lgc  = 1'b1;
               end
               dci_pkg::OP_XOR_REG: begin
                  lres = acc_hi ^ rf_q[instr_idx];
                  lgc  = 1'b1;
               end
               dci_pkg::OP_JUMP: pc_d = instr_target;
               dci_pkg::OP_BREAK: brk = 1'b1;
               dci_pkg::OP_CALL: begin
                  push = 1'b1;
                  pc_d = instr_target;
               end
               dci_pkg::OP_LBC: lbc_we = 1'b1;
               dci_pkg::OP_CLR_ACC: begin
                  acc_we = 1'b1;
                  if (instr_dw) begin
                     acc_d = dci_pkg::ACC_RST;
                  end else begin
                     acc_d[A-1:W] = dci_pkg::WORD_RST;
                  end
               end
               dci_pkg::OP_CLR_REG: begin
                  rf_we = 1'b1;
                  rf_wd = dci_pkg::WORD_RST;
               end
               dci_pkg::OP_CMP: begin
                  unique case (instr_src)
                     dci_pkg::SRC_REG: begin
                        flg_we = 1'b1;
                        flg_d  = cmp16(acc_hi, rf_q[instr_idx]);
                     end
                     dci_pkg::SRC_DMEM: begin
                        go_mem = 1'b1;
                        pc_we  = 1'b0;
                     end
                     dci_pkg::SRC_PMEM: begin
                        go_mem  = 1'b1;
                        go_pmem = 1'b1;
                        pc_we   = 1'b0;
                     end
                     default: begin
                     end
                  endcase
               end
               dci_pkg::OP_CMP_IMM: begin
                  flg_we = 1'b1;
                  flg_d  = cmp16(acc_hi, instr_imm);
               end
               dci_pkg::OP_CMP_SHORT_IMMEDIATE: begin
                  flg_we = 1'b1;
                  flg_d  = cmp16(acc_hi, short_immediate_s);
               end
               dci_pkg::OP_INV: begin
                  acc_we = 1'b1;
                  if (instr_dw) begin
                     acc_d = ~acc_q;
                  end else begin
                     acc_d[A-1:W] = ~acc_hi;
                  end
               end
               dci_pkg::OP_DOUBLE_WORD_ADD: begin
                  acc_we  = 1'b1;
                  acc_d   = dsum[A-1:0];
                  prod_we = instr_prod;
                  flg_we  = 1'b1;
                  flg_d.z = dsum[A-1:0] == dci_pkg::ACC_RST;
                  flg_d.n = dsum[A-1];
                  flg_d.c = dsum[A];
                  flg_d.v = (acc_q[A-1] == prod[A-1]) & (dsum[A-1] != acc_q[A-1]);
               end
               dci_pkg::OP_DOUBLE_WORD_SUBTRACT: begin
                  acc_we  = 1'b1;
                  acc_d   = ddif[A-1:0];
                  prod_we = instr_prod;
                  flg_we  = 1'b1;
                  flg_d.z = ddif[A-1:0] == dci_pkg::ACC_RST;
                  flg_d.n = ddif[A-1];
                  flg_d.c = ~ddif[A];
                  flg_d.v = (acc_q[A-1] != prod[A-1]) & (ddif[A-1] != acc_q[A-1]);
               end
               dci_pkg::OP_LOOP: begin
                  // Counter steps down on each taken pass so the loop can end
                  if (rf_q[lc_i] != dci_pkg::WORD_RST) begin
                     rf_we = 1'b1;
                     rf_wi = lc_i;
                     rf_wd = rf_q[lc_i] - dci_pkg::WORD_ONE;
                     pc_d  = instr_target;
                  end
               end
               dci_pkg::OP_DEC_ACC: begin
                  acc_we = 1'b1;
                  if (instr_dw) begin
                     acc_d = acc_q - dci_pkg::ACC_ONE;
                  end else begin
                     acc_d[A-1:W] = acc_hi - dci_pkg::WORD_ONE;
                  end
               end
               dci_pkg::OP_DEC_REG: begin
                  rf_we = 1'b1;
                  rf_wd = rf_q[instr_idx] - dci_pkg::WORD_ONE;
               end
               dci_pkg::OP_DEC_MEM: begin
                  go_mem = 1'b1;
                  pc_we  = 1'b0;
               end
               default: begin
               end
            endcase
            if (lgc) begin
               acc_we       = 1'b1;
               acc_d[A-1:W] = lres;
               flg_we       = 1'b1;
               flg_d.z      = lres == dci_pkg::WORD_RST;
               flg_d.n      = lres[W-1];
            end
         end
      end else if (state_q == dci_pkg::ST_DATA) begin
         pc_we = 1'b1;
         if (mop_q == dci_pkg::OP_DEC_MEM) begin
            mem_wr = 1'b1;
         end else begin
            flg_we = 1'b1;
            flg_d  = cmp16(acc_hi, mword);
         end
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         dci_pkg::ST_IDLE: if (go_mem) state_d = dci_pkg::ST_WAIT;
         dci_pkg::ST_WAIT: state_d = dci_pkg::ST_DATA;
         dci_pkg::ST_DATA: state_d = dci_pkg::ST_IDLE;
         default:          state_d = dci_pkg::ST_IDLE;
      endcase
   end

   // Break sets halt even if resume arrives in the same cycle
   assign halt_d = brk | (halt_q & ~debug_resume);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q  <= dci_pkg::ST_IDLE;
         mop_q    <= dci_pkg::OP_NOP;
         msrc_q   <= dci_pkg::SRC_REG;
         halt_q   <= 1'b0;
         ready_q  <= 1'b0;
         retire_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         halt_q   <= halt_d;
         ready_q  <= (state_d == dci_pkg::ST_IDLE) & ~halt_d;
         retire_q <= pc_we;
         if (go_mem) begin
            mop_q  <= instr_op;
            msrc_q <= go_pmem ? dci_pkg::SRC_PMEM : dci_pkg::SRC_DMEM;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_q <= dci_pkg::ACC_RST;
      end else if (acc_we) begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_q <= dci_pkg::WORD_RST;
         pl_q <= dci_pkg::WORD_RST;
      end else if (prod_we) begin
         ph_q <= acc_d[A-1:W];
         pl_q <= acc_d[W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_q <= '{z: 1'b0, n: 1'b0, c: 1'b0, v: 1'b0};
         lcnt_q  <= dci_pkg::CNT_RST;
      end else begin
         if (flg_we) flags_q <= flg_d;
         if (lbc_we) lcnt_q <= lbc.count;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_q <= dci_pkg::PC_RST;
      end else if (pc_we) begin
         pc_q <= pc_d;
      end
   end

   // Instruction writes win over a simultaneous external load to the same entry
   for (genvar g = 0; g < dci_pkg::RF_N; g++) begin : g_rf
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            rf_q[g] <= dci_pkg::WORD_RST;
         end else if (rf_we && rf_wi == dci_pkg::RF_IW'(g)) begin
            rf_q[g] <= rf_wd;
         end else if (reg_load_en && reg_load_idx == dci_pkg::RF_IW'(g)) begin
            rf_q[g] <= reg_load_data;
         end
      end
   end

   // Shift-register stack; overflow silently drops the deepest entry
   for (genvar g = 0; g < dci_pkg::STK_N; g++) begin : g_stk
      if (g == 0) begin : g_top
         assign push_src[g] = pc_q;
      end else begin : g_dn
         assign push_src[g] = stk_q[g-1];
      end
      if (g == dci_pkg::STK_N - 1) begin : g_bot
         assign pop_src[g] = dci_pkg::WORD_RST;
      end else begin : g_up
         assign pop_src[g] = stk_q[g+1];
      end
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            stk_q[g] <= dci_pkg::WORD_RST;
         end else if (push) begin
            stk_q[g] <= push_src[g];
         end else if (ret_pop) begin
            stk_q[g] <= pop_src[g];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         daddr_q <= dci_pkg::WORD_RST;
         paddr_q <= dci_pkg::WORD_RST;
         wdata_q <= dci_pkg::WORD_RST;
         drd_q   <= 1'b0;
         prd_q   <= 1'b0;
         dwr_q   <= 1'b0;
      end else begin
         drd_q <= go_mem & ~go_pmem;
         prd_q <= go_pmem;
         dwr_q <= mem_wr;
         if (go_mem && go_pmem) paddr_q <= instr_target;
         if (go_mem && !go_pmem) daddr_q <= rf_q[instr_idx];
         if (mem_wr) wdata_q <= dmem_rdata - dci_pkg::WORD_ONE;
      end
   end

   assign instr_ready       = ready_q;
   assign retire            = retire_q;
   assign halted            = halt_q;
   assign pc                = pc_q;
   assign return_top        = stk_q[0];
   assign acc               = acc_q;
   assign product_high_word = ph_q;
   assign product_low_word  = pl_q;
   assign flags             = flags_q;
   assign lead_count        = lcnt_q;
   assign dmem_addr         = daddr_q;
   assign dmem_rd           = drd_q;
   assign dmem_wr           = dwr_q;
   assign dmem_wdata        = wdata_q;
   assign pmem_addr         = paddr_q;
   assign pmem_rd           = prd_q;
endmodule

// ---- dv/dci_core_sva.sv ----
// Port checker for the instruction executor
`timescale 1ns/1ns
module dci_core_sva (
   input logic               clk,
   input logic               rst_n,
   input logic               instr_valid,
   input logic               instr_ready,
   input dci_pkg::dci_op_e   instr_op,
   input dci_pkg::dci_cond_e instr_cond,
   input logic               instr_dw,
   input logic [15:0]        instr_imm,
   input logic [15:0]        instr_target,
   input logic               retire,
   input logic               halted,
   input logic [15:0]        pc,
   input logic [31:0]        acc,
   input dci_pkg::dci_flags_s flags,
   input logic [5:0]         lead_count,
   input logic               dmem_rd,
   input logic               dmem_wr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire tk = instr_valid && instr_ready && instr_cond == dci_pkg::COND_ALWAYS;
   // Memory answers one cycle after the read strobe, so the write lands in the third cycle
   sequence mem_s;
      dmem_rd ##1 !dmem_rd ##1 (dmem_wr && retire);
   endsequence
   and_imm_a: assert property (tk && instr_op == dci_pkg::OP_AND_IMM
      |=> acc[31:16] == ($past(acc[31:16]) & $past(instr_imm))) else $error("and immediate wrong");
   jump_a: assert property (tk && instr_op == dci_pkg::OP_JUMP |=> pc == $past(instr_target))
      else $error("jump target wrong");
   brk_stop_a: assert property (tk && instr_op == dci_pkg::OP_BREAK |=> retire && !instr_ready)
      else $error("break did not stop");
   halt_idle_a: assert property (halted |-> !instr_ready)
      else $error("ready while halted");
   dec_mem_a: assert property (tk && instr_op == dci_pkg::OP_DEC_MEM |=> mem_s)
      else $error("memory decrement sequence wrong");
   clr_acc_a: assert property (tk && instr_op == dci_pkg::OP_CLR_ACC && instr_dw |=> acc == 32'h0)
      else $error("clear left bits");
   inv_acc_a: assert property (tk && instr_op == dci_pkg::OP_INV && instr_dw |=> acc == ~$past(acc))
      else $error("invert wrong");
   dec_acc_a: assert property (tk && instr_op == dci_pkg::OP_DEC_ACC && instr_dw
      |=> acc == $past(acc) - 32'h1) else $error("decrement wrong");
   lead_zero_a: assert property (tk && instr_op == dci_pkg::OP_LBC && acc == 32'h0 |=> lead_count == 6'h1f)
      else $error("lead count wrong");
   skip_jump_a: assert property (instr_valid && instr_ready && instr_op == dci_pkg::OP_JUMP
      && instr_cond == dci_pkg::COND_NE && flags.z |=> retire && pc == $past(pc) + 16'h1 && acc == $past(acc))
      else $error("false condition changed state");
endmodule
bind dci_core dci_core_sva u_sva (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
   .instr_ready(instr_ready), .instr_op(instr_op), .instr_cond(instr_cond), .instr_dw(instr_dw),
   .instr_imm(instr_imm), .instr_target(instr_target), .retire(retire), .halted(halted), .pc(pc),
   .acc(acc), .flags(flags), .lead_count(lead_count), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr));

// ---- dv/dci_core_bench.sv ----
// Self-checking bench for the instruction executor
`timescale 1ns/1ns
module dci_core_bench;
   localparam dci_pkg::dci_cond_e AL = dci_pkg::COND_ALWAYS;
   logic                clk = 1'b0;
   logic                rst_n, vld, dw, res, ld_en, rdy, ret, hlt, drd, dwr, prd;
   dci_pkg::dci_op_e    op;
   dci_pkg::dci_cond_e  cnd;
   dci_pkg::dci_src_e   src;
   dci_pkg::dci_flags_s flg;
   logic [2:0]          idx, ld_idx;
   logic [15:0]         full_immediate, ld_dat, drdat, prdat, mem_w, pc, rtop, dadr, dwdat, m_pc;
   logic [31:0]         acc, m_acc, rnd, sv;
   logic [5:0]          lcnt;
   logic [47:0]         exp_q[$];
   logic [47:0]         e48;
   int                  fail_count = 0, checks_done = 0;

   always #50 clk = ~clk;
   // Released read data flips each cycle, so a sample one cycle late is inverted and does not look right
   always @(posedge clk) begin
      drdat <= drd ? mem_w : ~drdat;
      prdat <= prd ? mem_w : ~prdat;
   end

   dci_core uut (.clk(clk), .rst_n(rst_n), .instr_valid(vld), .instr_op(op), .instr_cond(cnd),
      .instr_src(src), .instr_dw(dw), .instr_prod(dw), .instr_idx(idx), .instr_imm(full_immediate),
      .instr_target(full_immediate), .debug_resume(res), .ret_pop(1'b0), .reg_load_en(ld_en), .reg_load_idx(ld_idx),
      .reg_load_data(ld_dat), .dmem_rdata(drdat), .pmem_rdata(prdat), .instr_ready(rdy), .retire(ret),
      .halted(hlt), .pc(pc), .return_top(rtop), .acc(acc), .product_high_word(), .product_low_word(),
      .flags(flg), .lead_count(lcnt), .dmem_addr(dadr), .dmem_rd(drd), .dmem_wr(dwr), .dmem_wdata(dwdat),
      .pmem_addr(), .pmem_rd(prd));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Offers one instruction and notes the expected accumulator and program counter
   task run(input dci_pkg::dci_op_e o, input dci_pkg::dci_cond_e c, input logic [2:0] i,
            input logic [15:0] m, input logic d, input logic [31:0] a, input logic [15:0] p);
      int n;
      n = 0;
      @(posedge clk);
      op <= o;
      cnd <= c;
      idx <= i;
      full_immediate <= m;
      dw <= d;
      vld <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (rdy !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end
      vld <= 1'b0;
      exp_q.push_back({a, p});
      m_acc = a;
      m_pc = p;
   endtask

   task ld(input logic [2:0] i, input logic [15:0] v);
      @(posedge clk);
      ld_en <= 1'b1;
      ld_idx <= i;
      ld_dat <= v;
      @(posedge clk);
      ld_en <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (ret === 1'b1) begin
         e48 = exp_q.size() > 0 ? exp_q.pop_front() : 48'h0;
         chk("acc", e48[47:16], acc);
         chk("pc", {16'h0, e48[15:0]}, {16'h0, pc});
      end
   end

   initial begin
      logic [15:0] r1;
      {rst_n, vld, dw, res, ld_en} = 5'h0;
      {idx, ld_idx} = '0;
      op = dci_pkg::OP_NOP;
      cnd = AL;
      src = dci_pkg::SRC_PMEM;
      {full_immediate, ld_dat, mem_w} = '0;
      {m_acc, m_pc} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rnd = lfsr(32'h47ded228);
      r1 = rnd[15:0];
      ld(3'h1, r1);
      ld(3'h6, 16'h0002);
      run(dci_pkg::OP_INV, AL, 3'h0, 16'h0, 1'b1, ~m_acc, m_pc + 16'h1);
      rnd = lfsr(rnd);
      run(dci_pkg::OP_AND_SHORT_IMMEDIATE, AL, 3'h0, rnd[15:0], 1'b0,
          {m_acc[31:16] & {8'h00, rnd[7:0]}, m_acc[15:0]}, m_pc + 16'h1);
      run(dci_pkg::OP_XOR_REG, AL, 3'h1, 16'h0, 1'b0, {m_acc[31:16] ^ r1, m_acc[15:0]}, m_pc + 16'h1);
      run(dci_pkg::OP_AND_PTR, AL, 3'h1, 16'h0, 1'b0, {m_acc[31:16] & r1, m_acc[15:0]}, m_pc + 16'h1);
      run(dci_pkg::OP_AND_IMM, AL, 3'h0, rnd[31:16], 1'b0,
          {m_acc[31:16] & rnd[31:16], m_acc[15:0]}, m_pc + 16'h1);
      run(dci_pkg::OP_DEC_ACC, AL, 3'h0, 16'h0, 1'b0, {m_acc[31:16] - 16'h1, m_acc[15:0]}, m_pc + 16'h1);
      run(dci_pkg::OP_DEC_ACC, AL, 3'h0, 16'h0, 1'b1, m_acc - 32'h1, m_pc + 16'h1);
      sv = m_acc;
      run(dci_pkg::OP_DOUBLE_WORD_ADD, AL, 3'h0, 16'h0, 1'b1, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_DOUBLE_WORD_ADD, AL, 3'h0, 16'h0, 1'b0, {m_acc[30:0], 1'b0}, m_pc + 16'h1);
      run(dci_pkg::OP_DOUBLE_WORD_SUBTRACT, AL, 3'h0, 16'h0, 1'b0, sv, m_pc + 16'h1);
      run(dci_pkg::OP_CMP_IMM, AL, 3'h0, m_acc[31:16], 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_JUMP, dci_pkg::COND_NE, 3'h0, 16'h0040, 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_JUMP, dci_pkg::COND_EQ, 3'h0, 16'h0040, 1'b0, m_acc, 16'h0040);
      run(dci_pkg::OP_CLR_ACC, AL, 3'h0, 16'h0, 1'b1, 32'h0, m_pc + 16'h1);
      run(dci_pkg::OP_LBC, AL, 3'h0, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_DEC_ACC, AL, 3'h0, 16'h0, 1'b0, 32'hffff0000, m_pc + 16'h1);
      run(dci_pkg::OP_LBC, AL, 3'h0, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      @(negedge clk);
      chk("lead", 32'h0f, {26'h0, lcnt});
      // Only a sign-extended 8'hff equals the all-ones high word
      run(dci_pkg::OP_CMP_SHORT_IMMEDIATE, AL, 3'h0, 16'h00ff, 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_JUMP, dci_pkg::COND_EQ, 3'h0, 16'h0080, 1'b0, m_acc, 16'h0080);
      run(dci_pkg::OP_CALL, AL, 3'h0, 16'h0100, 1'b0, m_acc, 16'h0100);
      @(negedge clk);
      chk("return", 32'h0080, {16'h0, rtop});
      for (int k = 0; k < 3; k++)
         run(dci_pkg::OP_LOOP, AL, 3'h6, 16'h0200, 1'b0, m_acc, k < 2 ? 16'h0200 : m_pc + 16'h1);
      run(dci_pkg::OP_DEC_REG, AL, 3'h6, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_LOOP, AL, 3'h6, 16'h0300, 1'b0, m_acc, 16'h0300);
      rnd = lfsr(rnd);
      mem_w = rnd[15:0];
      run(dci_pkg::OP_DEC_MEM, AL, 3'h1, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("wdata", {16'h0, mem_w - 16'h1}, {16'h0, dwdat});
      chk("addr", {16'h0, r1}, {16'h0, dadr});
      mem_w = m_acc[31:16] ^ 16'h0001;
      run(dci_pkg::OP_CMP, AL, 3'h0, 16'h0400, 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_JUMP, dci_pkg::COND_NE, 3'h0, 16'h0500, 1'b0, m_acc, 16'h0500);
      src <= dci_pkg::SRC_REG;
      run(dci_pkg::OP_CMP, AL, 3'h7, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      @(posedge clk);
      chk("flags", 32'h6, {28'h0, flg});
      src <= dci_pkg::SRC_DMEM;
      mem_w = 16'hffff;
      run(dci_pkg::OP_CMP, AL, 3'h1, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      run(dci_pkg::OP_JUMP, dci_pkg::COND_EQ, 3'h0, 16'h0700, 1'b0, m_acc, 16'h0700);
      run(dci_pkg::OP_BREAK, AL, 3'h0, 16'h0, 1'b0, m_acc, m_pc + 16'h1);
      repeat (3) @(negedge clk);
      chk("halt", 32'h2, {30'h0, hlt, rdy});
      @(posedge clk);
      res <= 1'b1;
      @(posedge clk);
      res <= 1'b0;
      run(dci_pkg::OP_INV, AL, 3'h0, 16'h0, 1'b0, {~m_acc[31:16], m_acc[15:0]}, m_pc + 16'h1);
      repeat (10) @(posedge clk);
      chk("pending", 32'h0, exp_q.size());
      report_and_stop();
   end
endmodule
